/* rtl/boundary_scan_test_port.sv */
// boundary scan test port: instruction decode, data registers, aux pin cells
`timescale 1ns/10ps
module boundary_scan_test_port (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    input wire logic [7:0] aux_bidir_pin_in,
    output logic [7:0] aux_bidir_pin_out,
    output logic [7:0] aux_bidir_pin_oe_n,
    input wire logic [7:0] core_aux_out,
    input wire logic core_aux_dir_in,
    input wire logic [81:0] core_pins,
    output logic [81:0] core_pins_update
);
    tap_if tap ();
    // tester owns tap sequencing via tck and tms
    tap_sampler u_sampler (
        .mclk(mclk),
        .reset_n(reset_n),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tap(tap.ctrl)
    );
    logic [2:0] ir_reg, ir_next, ir_shift_reg, ir_shift_next;
    logic [97:0] bsr_reg, bsr_next, bsr_upd_reg, bsr_upd_next;
    logic [31:0] id_reg, id_next;
    logic byp_reg, byp_next;
    logic tdo_reg, tdo_next, oe_n_reg, oe_n_next;
    logic [7:0] pin_out_reg, pin_out_next, pin_oe_n_reg, pin_oe_n_next;
    logic [81:0] core_upd_reg, core_upd_next;
    logic [97:0] capture_vec;
    logic ext_mode, chain_sel, upd_now;
    logic [7:0] aux_in_s1_reg, aux_in_s2_reg, aux_in_s3_reg;
    logic [81:0] core_s1_reg, core_s2_reg;
    ////////////////////////////////////////////////////////////////////
    // aux pins from outside pass three flops and core pins two before capture
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            aux_in_s1_reg <= 8'h00;
            aux_in_s2_reg <= 8'h00;
            aux_in_s3_reg <= 8'h00;
            core_s1_reg <= '0;
            core_s2_reg <= '0;
        end else begin
            aux_in_s1_reg <= aux_bidir_pin_in;
            aux_in_s2_reg <= aux_in_s1_reg;
            aux_in_s3_reg <= aux_in_s2_reg;
            core_s1_reg <= core_pins;
            core_s2_reg <= core_s1_reg;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // capture vector: even cell holds driven value, odd cell pin level
    for (genvar i = 0; i < scan_pkg::AUX_PINS; i++) begin : g_cells
        assign capture_vec[2*i] = pin_out_reg[i];
        assign capture_vec[2*i+1] = aux_in_s3_reg[i];
    end
    assign capture_vec[97:16] = core_s2_reg;
    assign ext_mode = (ir_reg == scan_pkg::IR_EXTEST);
    assign chain_sel = ext_mode || (ir_reg == scan_pkg::IR_SAMPLE);
    assign upd_now = tap.rise && (tap.state == scan_pkg::TAP_UPD_DR);
    ////////////////////////////////////////////////////////////////////
    // instruction and data registers, stepped on test clock rises
    always_comb begin
        ir_next = ir_reg;
        ir_shift_next = ir_shift_reg;
        bsr_next = bsr_reg;
        bsr_upd_next = bsr_upd_reg;
        id_next = id_reg;
        byp_next = byp_reg;
        if (tap.rise) begin
            unique case (tap.state)
                scan_pkg::TAP_RESET: ir_next = scan_pkg::IR_RESET_VALUE;
                scan_pkg::TAP_CAP_IR: ir_shift_next = 3'h1;
                // lsb leaves first, new bit enters at the top
                scan_pkg::TAP_SHIFT_IR: ir_shift_next = {tap.tdi, ir_shift_reg[2:1]};
                scan_pkg::TAP_UPD_IR: ir_next = ir_shift_reg;
                scan_pkg::TAP_CAP_DR: begin
                    if (chain_sel) begin
                        bsr_next = capture_vec;
                    end
                    id_next = scan_pkg::ID_VALUE;
                    byp_next = 1'b0;
                end
                scan_pkg::TAP_SHIFT_DR: begin
                    if (chain_sel) begin
                        bsr_next = {tap.tdi, bsr_reg[97:1]};
                    end else if (ir_reg == scan_pkg::IR_IDCODE) begin
                        id_next = {tap.tdi, id_reg[31:1]};
                    end else begin
                        byp_next = tap.tdi;
                    end
                end
                scan_pkg::TAP_UPD_DR: begin
                    if (chain_sel) begin
                        bsr_upd_next = bsr_reg;
                    end
                end
                default: ;
            endcase
        end
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ir_reg <= scan_pkg::IR_RESET_VALUE;
            ir_shift_reg <= 3'h1;
            bsr_reg <= '0;
            bsr_upd_reg <= '0;
            id_reg <= scan_pkg::ID_VALUE;
            byp_reg <= 1'b0;
        end else begin
            ir_reg <= ir_next;
            ir_shift_reg <= ir_shift_next;
            bsr_reg <= bsr_next;
            bsr_upd_reg <= bsr_upd_next;
            id_reg <= id_next;
            byp_reg <= byp_next;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // tdo changes on the falling test clock, as a tester expects
    always_comb begin
        tdo_next = tdo_reg;
        oe_n_next = oe_n_reg;
        if (tap.fall) begin
            oe_n_next = !((tap.state == scan_pkg::TAP_SHIFT_DR) ||
                          (tap.state == scan_pkg::TAP_SHIFT_IR));
            if (tap.state == scan_pkg::TAP_SHIFT_IR) begin
                tdo_next = ir_shift_reg[0];
            end else if (chain_sel) begin
                tdo_next = bsr_reg[0];
            end else if (ir_reg == scan_pkg::IR_IDCODE) begin
                tdo_next = id_reg[0];
            end else begin
                tdo_next = byp_reg;
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tdo_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else begin
            tdo_reg <= tdo_next;
            oe_n_reg <= oe_n_next;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // pin muxing: extest drives from update latch, else core paths kept
    always_comb begin
        for (int i = 0; i < scan_pkg::AUX_PINS; i++) begin
            pin_out_next[i] = ext_mode ? bsr_upd_reg[2*i] : core_aux_out[i];
        end
        pin_oe_n_next = ext_mode ? 8'h00 : {8{core_aux_dir_in}};
        core_upd_next = ext_mode ? bsr_upd_reg[97:16] : core_upd_reg;
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pin_out_reg <= 8'h00;
            pin_oe_n_reg <= 8'hFF;
            core_upd_reg <= '0;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_n_reg <= pin_oe_n_next;
            core_upd_reg <= core_upd_next;
        end
    end
    assign tdo = tdo_reg;
    assign tdo_oe_n = oe_n_reg;
    assign aux_bidir_pin_out = pin_out_reg;
    assign aux_bidir_pin_oe_n = pin_oe_n_reg;
    assign core_pins_update = core_upd_reg;
    ////////////////////////////////////////////////////////////////////
    // checks
    sequence upd_seq;
        upd_now && ext_mode;
    endsequence
    ext_drive_a: assert property (@(posedge mclk) disable iff (!reset_n)
        upd_seq |=> ##1 (pin_out_reg[0] == $past(bsr_reg[0], 2)))
        else $error("extest pin not driven from chain");
    id_load_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (tap.rise && tap.state == scan_pkg::TAP_CAP_DR) |=> (id_reg[0] == 1'b1))
        else $error("id bit zero not one");
    id_shift_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (tap.rise && tap.state == scan_pkg::TAP_SHIFT_DR && ir_reg == scan_pkg::IR_IDCODE)
        |=> (id_reg[30:0] == $past(id_reg[31:1])))
        else $error("id not shifted lsb first");
    bypass_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (tap.rise && tap.state == scan_pkg::TAP_SHIFT_DR && ir_reg == scan_pkg::IR_BYPASS)
        |=> (byp_reg == $past(tap.tdi)))
        else $error("bypass stage wrong");
    ir_update_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (tap.rise && tap.state == scan_pkg::TAP_UPD_IR) |=> (ir_reg == $past(ir_shift_reg)))
        else $error("instruction not updated");
    capture_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (tap.rise && tap.state == scan_pkg::TAP_CAP_DR && chain_sel)
        |=> (bsr_reg[1] == $past(aux_in_s3_reg[0])))
        else $error("pin level not captured");
    sample_keep_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (ir_reg == scan_pkg::IR_SAMPLE) ##1 (ir_reg == scan_pkg::IR_SAMPLE)
        |-> (pin_out_reg == $past(core_aux_out)))
        else $error("sample broke core path");
    tdo_src_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (tap.fall && tap.state == scan_pkg::TAP_SHIFT_DR && chain_sel)
        |=> (tdo_reg == $past(bsr_reg[0])))
        else $error("chain not on tdo");
    id_on_tdo_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (tap.fall && tap.state == scan_pkg::TAP_SHIFT_DR && ir_reg == scan_pkg::IR_IDCODE)
        |=> (tdo_reg == $past(id_reg[0])))
        else $error("id not on tdo");
endmodule // boundary_scan_test_port

/* rtl/scan_pkg.sv */
// constants for the boundary scan test port
package scan_pkg;
    localparam int IR_WIDTH = 3;
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_SAMPLE = 3'h4;
    localparam logic [2:0] IR_IDCODE = 3'h6;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    localparam logic [2:0] IR_RESET_VALUE = 3'h6;
    localparam int BSR_LEN = 98;
    localparam int AUX_PINS = 8;
    localparam int CORE_BITS = BSR_LEN - 2 * AUX_PINS;
    localparam int ID_WIDTH = 32;
    localparam int ID_PRODUCER_LSB = 1;
    localparam int ID_PART_LSB = 12;
    localparam int ID_REV_LSB = 28;
    // arbitrary identity values
    localparam logic [10:0] ID_PRODUCER = 11'h155;
    localparam logic [15:0] ID_PART = 16'h1234;
    localparam logic [3:0] ID_REVISION = 4'h1;
    localparam logic [31:0] ID_VALUE = {ID_REVISION, ID_PART, ID_PRODUCER, 1'b1};
    localparam logic [3:0] TAP_RESET = 4'h0;
    localparam logic [3:0] TAP_IDLE = 4'h1;
    localparam logic [3:0] TAP_SEL_DR = 4'h2;
    localparam logic [3:0] TAP_CAP_DR = 4'h3;
    localparam logic [3:0] TAP_SHIFT_DR = 4'h4;
    localparam logic [3:0] TAP_EXIT1_DR = 4'h5;
    localparam logic [3:0] TAP_PAUSE_DR = 4'h6;
    localparam logic [3:0] TAP_EXIT2_DR = 4'h7;
    localparam logic [3:0] TAP_UPD_DR = 4'h8;
    localparam logic [3:0] TAP_SEL_IR = 4'h9;
    localparam logic [3:0] TAP_CAP_IR = 4'hA;
    localparam logic [3:0] TAP_SHIFT_IR = 4'hB;
    localparam logic [3:0] TAP_EXIT1_IR = 4'hC;
    localparam logic [3:0] TAP_PAUSE_IR = 4'hD;
    localparam logic [3:0] TAP_EXIT2_IR = 4'hE;
    localparam logic [3:0] TAP_UPD_IR = 4'hF;
endpackage

/* rtl/tap_if.sv */
// tap state and edge strobes from the sampler to the scan core
`timescale 1ns/10ps
interface tap_if;
    logic rise;
    logic fall;
    logic tms;
    logic tdi;
    logic [3:0] state;
    modport ctrl (output rise, fall, tms, tdi, state);
    modport core (input rise, fall, tms, tdi, state);
endinterface

/* rtl/tap_sampler.sv */
// synchronises the test pins, finds test clock edges, runs the tap states
`timescale 1ns/10ps
module tap_sampler (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    tap_if.ctrl tap
);
    logic [1:0] s1_reg, s1_next;
    logic [1:0] s2_reg, s2_next;
    logic tck_old_reg, tck_old_next;
    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
        ST_SHIFT_DR = 4'h4, ST_EXIT1_DR = 4'h5, ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7, ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'hA, ST_SHIFT_IR = 4'hB, ST_EXIT1_IR = 4'hC,
        ST_PAUSE_IR = 4'hD, ST_EXIT2_IR = 4'hE, ST_UPD_IR = 4'hF
    } tap_state_t;
    tap_state_t state_reg, state_next;
    logic tms_s, tdi_s, tck_s;
    // tdi runs one stage behind tck so it is settled when the rise is seen
    logic d1_reg, d2_reg, tdi_hold_reg;
    assign tck_s = s2_reg[0];
    assign tms_s = s2_reg[1];
    assign tdi_s = tdi_hold_reg;
    ////////////////////////////////////////////////////////////////////
    // two-flop synchroniser; tms and tdi sampled on the test clock rise
    always_comb begin
        s1_next = {tms, tck};
        s2_next = s1_reg;
        tck_old_next = tck_s;
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s1_reg <= 2'h0;
            s2_reg <= 2'h0;
            tck_old_reg <= 1'b0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            tck_old_reg <= tck_old_next;
        end
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            d1_reg <= 1'b0;
            d2_reg <= 1'b0;
            tdi_hold_reg <= 1'b0;
        end else begin
            d1_reg <= tdi;
            d2_reg <= d1_reg;
            tdi_hold_reg <= d2_reg;
        end
    end
    assign tap.rise = tck_s & ~tck_old_reg;
    assign tap.fall = ~tck_s & tck_old_reg;
    assign tap.tms = tms_s;
    assign tap.tdi = tdi_s;
    assign tap.state = state_reg;
    ////////////////////////////////////////////////////////////////////
    // standard tap sequencing, advanced on each test clock rise
    always_comb begin
        state_next = state_reg;
        if (tap.rise) begin
            unique case (state_reg)
                ST_RESET: state_next = tms_s ? ST_RESET : ST_IDLE;
                ST_IDLE: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
                ST_SEL_DR: state_next = tms_s ? ST_SEL_IR : ST_CAP_DR;
                ST_CAP_DR: state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_SHIFT_DR: state_next = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
                ST_EXIT1_DR: state_next = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
                ST_PAUSE_DR: state_next = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
                ST_EXIT2_DR: state_next = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
                ST_UPD_DR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
                ST_SEL_IR: state_next = tms_s ? ST_RESET : ST_CAP_IR;
                ST_CAP_IR: state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_SHIFT_IR: state_next = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
                ST_EXIT1_IR: state_next = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
                ST_PAUSE_IR: state_next = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
                ST_EXIT2_IR: state_next = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
                ST_UPD_IR: state_next = tms_s ? ST_SEL_DR : ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule // tap_sampler

/* tb/boundary_scan_test_port_tb_top.sv */
// self-checking bench for the boundary scan test port
`timescale 1ns/10ps
module boundary_scan_test_port_tb_top;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe_n, tdo_line;
    logic tdo_last = 1'b0;
    logic [7:0] aux_level, aux_bidir_pin_out, aux_bidir_pin_oe_n;
    logic [7:0] ext_level = 8'h5C;
    logic [7:0] core_aux_out = 8'h3A;
    logic core_aux_dir_in = 1'b1;
    logic [81:0] core_pins = 82'h2_A5A5_F00F_3C3C_96C3_1E2D;
    logic [81:0] core_pins_update;
    int fails = 0;
    int n_checks = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // released tdo shows the inverse of its last value, not a kind constant
    always @(posedge mclk) if (!tdo_oe_n) tdo_last <= tdo;
    assign tdo_line = tdo_oe_n ? ~tdo_last : tdo;
    // aux pins: device level where it drives, board level elsewhere
    assign aux_level = (aux_bidir_pin_oe_n & ext_level) | (~aux_bidir_pin_oe_n & aux_bidir_pin_out);
    boundary_scan_test_port dut_u (.mclk(mclk), .reset_n(reset_n), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .aux_bidir_pin_in(aux_level),
        .aux_bidir_pin_out(aux_bidir_pin_out), .aux_bidir_pin_oe_n(aux_bidir_pin_oe_n),
        .core_aux_out(core_aux_out), .core_aux_dir_in(core_aux_dir_in),
        .core_pins(core_pins), .core_pins_update(core_pins_update));
    scan_tester tester_u (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));
    ////////////////////////////////////////////////////////////////////////////////
    // masked compare; an unknown in a checked bit never matches
    task automatic check_vec(input logic [97:0] got, input logic [97:0] exp,
                             input logic [97:0] mask, input string what);
        n_checks++;
        if (((got ^ exp) & mask) !== '0) begin
            fails++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // identification after reset and after an explicit load
    task automatic test_ident();
        logic [97:0] got, exp;
        logic [2:0] cap;
        exp = '0;
        exp[0] = 1'b1;
        exp[11:1] = scan_pkg::ID_PRODUCER;
        exp[27:12] = scan_pkg::ID_PART;
        exp[31:28] = scan_pkg::ID_REVISION;
        check_vec({90'h0, aux_bidir_pin_oe_n}, 98'hFF, 98'hFF, "idle aux enables");
        tester_u.scan_dr(32, 98'h0, got);
        check_vec(got, exp, {66'h0, 32'hFFFF_FFFF}, "reset id");
        check_vec({97'h0, tdo_oe_n}, 98'h1, 98'h1, "tdo released");
        tester_u.load_ir(scan_pkg::IR_IDCODE, cap);
        check_vec({95'h0, cap}, 98'h1, 98'h7, "ir capture");
        tester_u.scan_dr(32, 98'h0, got);
        check_vec(got, exp, {66'h0, 32'hFFFF_FFFF}, "loaded id");
        $display("test ident done");
    endtask
    // bypass and every unknown code: one stage, zero captured first
    task automatic test_bypass();
        logic [97:0] got;
        logic [2:0] cap;
        logic [2:0] codes [5];
        codes = '{scan_pkg::IR_BYPASS, 3'h1, 3'h2, 3'h3, 3'h5};
        for (int c = 0; c < 5; c++) begin
            tester_u.load_ir(codes[c], cap);
            tester_u.scan_dr(10, 98'h2D3, got);
            check_vec(got, {87'h0, 10'h2D3, 1'b0}, 98'h3FF, "bypass");
        end
        $display("test bypass done");
    endtask
    // external test: update drives pins, second scan reads them back
    task automatic test_extest();
        logic [97:0] got, p1, p2, exp;
        logic [2:0] cap;
        p1 = 98'h3_1234_5678_9ABC_DEF0_1357_9BDF;
        p2 = 98'h1_F0E1_D2C3_B4A5_9687_7869_5A4B;
        tester_u.load_ir(scan_pkg::IR_EXTEST, cap);
        tester_u.scan_dr(98, p1, got);
        repeat (6) @(negedge mclk);
        for (int i = 0; i < 8; i++) begin
            check_vec({97'h0, aux_bidir_pin_out[i]}, {97'h0, p1[2 * i]}, 98'h1,
                      "pin out");
        end
        check_vec({90'h0, aux_bidir_pin_oe_n}, 98'h0, 98'hFF, "extest enables");
        check_vec({16'h0, core_pins_update}, {16'h0, p1[97:16]}, '1,
                  "core update");
        tester_u.scan_dr(98, p2, got);
        exp = {core_pins, 16'h0};
        // output cell holds the driven value, input cell the pin level
        for (int i = 0; i < 8; i++) exp[2 * i +: 2] = {2{p1[2 * i]}};
        check_vec(got, exp, '1, "extest capture");
        $display("test extest done");
    endtask
    // sample: chain captures pins while the core keeps the pins
    task automatic test_sample();
        logic [97:0] got, exp;
        logic [81:0] held;
        logic [2:0] cap;
        held = core_pins_update;
        @(negedge mclk);
        core_pins = 82'h1_0F1E_2D3C_4B5A_6978_8796;
        tester_u.load_ir(scan_pkg::IR_SAMPLE, cap);
        tester_u.scan_dr(98, 98'h2_AAAA_5555_0000_FFFF_1234_5678, got);
        exp = {core_pins, 16'h0};
        for (int i = 0; i < 8; i++) exp[2 * i +: 2] = {ext_level[i], core_aux_out[i]};
        check_vec(got, exp, '1, "sample capture");
        check_vec({90'h0, aux_bidir_pin_oe_n}, 98'hFF, 98'hFF, "sample hi-z");
        check_vec({16'h0, core_pins_update}, {16'h0, held}, '1, "update held");
        core_aux_dir_in = 1'b0;
        repeat (6) @(negedge mclk);
        check_vec({90'h0, aux_bidir_pin_out}, {90'h0, core_aux_out}, 98'hFF, "core out");
        check_vec({90'h0, aux_bidir_pin_oe_n}, 98'h0, 98'hFF, "core enables");
        $display("test sample done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // 200 MHz system clock
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (95000) @(posedge mclk);
        fails++;
        $display("mismatch at %0t: run did not finish", $time);
        tally_and_finish();
    end
    // main sequence
    initial begin
        repeat (10) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        tester_u.reset_tap();
        test_ident();
        test_bypass();
        test_extest();
        test_sample();
        tally_and_finish();
    end
endmodule // boundary_scan_test_port_tb_top

/* tb/scan_tester.sv */
// board tester model: walks the tap states, shifts test data in and out
`timescale 1ns/10ps
module scan_tester (
    input wire logic mclk,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // test clock rests low between frames; it never runs free
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one 160 ns test clock period; tdo is taken just before the rise
    task automatic tck_cycle(input logic m, input logic d, output logic q);
        @(negedge mclk);
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (16) @(negedge mclk);
        q = tdo;
        tck = 1'b1;
        repeat (15) @(negedge mclk);
    endtask
    // state step; data in toggles so a stray capture of it shows up
    task automatic walk(input logic m);
        logic q;
        tck_cycle(m, ~tdi, q);
    endtask
    task automatic frame_end();
        @(negedge mclk);
        tck = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // five ones reach test-logic-reset from anywhere, then park in idle
    task automatic reset_tap();
        repeat (5) walk(1'b1);
        walk(1'b0);
        frame_end();
    endtask
    // instruction goes in lsb first, capture pattern comes back
    task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
        walk(1'b1);
        walk(1'b1);
        walk(1'b0);
        walk(1'b0);
        for (int k = 0; k < 3; k++) begin
            tck_cycle(k == 2, code[k], cap[k]);
        end
        walk(1'b1);
        walk(1'b0);
        frame_end();
    endtask
    // capture, shift n bits lsb first, update, back to idle
    task automatic scan_dr(input int n, input logic [97:0] din, output logic [97:0] dout);
        dout = '0;
        walk(1'b1);
        walk(1'b0);
        walk(1'b0);
        for (int k = 0; k < n; k++) begin
            tck_cycle(k == n - 1, din[k], dout[k]);
        end
        walk(1'b1);
        walk(1'b0);
        frame_end();
    endtask
endmodule // scan_tester
